/* File: dv/cad_core_checker.sv */
// concurrent checks on the core ports
// assumes it is bound to cad_core and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module cad_core_checker (
   input wire logic        ref_clk,
   input wire logic        resetn,
   input wire logic [15:0] mem_addr,
   input wire logic        mem_re,
   input wire logic        mem_we,
   input wire logic [7:0]  mem_rdata,
   input wire logic        fetch_strobe,
   input wire logic [7:0]  acc_out,
   input wire logic [7:0]  idx_out,
   input wire logic [4:0]  ccr_out
);
   // ==========
   // opcode fields, valid in the fetch cycle only
   wire [3:0] op_row = mem_rdata[7:4];
   wire [3:0] op_fn = mem_rdata[3:0];
   // stores, jumps and calls take other lengths, so they are left out
   wire rm_read = op_fn inside {[4'h0:4'h6], [4'h8:4'hb], 4'he};
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   sequence s_fetch_op(op);
      fetch_strobe && mem_rdata == op;
   endsequence
   sequence s_fetch_row(row);
      fetch_strobe && op_row == row && rm_read;
   endsequence
   sequence s_write_same;
      mem_we && mem_addr == $past(mem_addr);
   endsequence
   property p_rmw_back;
      fetch_strobe && op_row == 4'h3 &&
         !(op_fn inside {4'h1, 4'h2, 4'h5, 4'hb, 4'hd, 4'he})
         |-> ##3 s_write_same ##2 fetch_strobe;
   endproperty
   a_rmw_back: assert property (p_rmw_back)
      else $error("write-back missing or misplaced");
   property p_probe;
      s_fetch_op(8'h3d) |=> (!mem_we)[*3] ##1 fetch_strobe;
   endproperty
   a_probe: assert property (p_probe)
      else $error("probe wrote or took wrong length");
   property p_prod;
      s_fetch_op(8'h42) |=> {idx_out, acc_out} ==
         $past(acc_out) * $past(idx_out) && ccr_out[4] == 1'b0 &&
         ccr_out[0] == 1'b0 && ccr_out[3:1] == $past(ccr_out[3:1])
         ##0 (!fetch_strobe)[*8] ##3 fetch_strobe;
   endproperty
   a_prod: assert property (p_prod)
      else $error("product result, flags or length wrong");
   property p_imm;
      s_fetch_row(4'ha) |=> !fetch_strobe ##1 fetch_strobe;
   endproperty
   a_imm: assert property (p_imm)
      else $error("immediate length wrong");
   property p_ext;
      s_fetch_row(4'hc) |-> ##3 mem_re &&
         mem_addr == {$past(mem_rdata, 2), $past(mem_rdata)} ##1 fetch_strobe;
   endproperty
   a_ext: assert property (p_ext)
      else $error("extended address or length wrong");
   property p_ix;
      s_fetch_row(4'hf) |=> mem_re && mem_addr == {8'h00, idx_out}
         ##2 fetch_strobe;
   endproperty
   a_ix: assert property (p_ix)
      else $error("indexed address or length wrong");
   property p_ctl;
      fetch_strobe && mem_rdata inside {[8'h97:8'h9f]}
         |=> !mem_we && !mem_re ##1 fetch_strobe;
   endproperty
   a_ctl: assert property (p_ctl)
      else $error("control op touched memory");
   property p_rol;
      s_fetch_op(8'h49) |=> acc_out == (8'($past(acc_out) << 1) |
         8'($past(ccr_out) & 5'h01)) &&
         ccr_out[0] == ($past(acc_out) >= 8'h80) ##2 fetch_strobe;
   endproperty
   a_rol: assert property (p_rol)
      else $error("rotate result or length wrong");
endmodule : cad_core_checker
bind cad_core cad_core_checker chk (.ref_clk, .resetn, .mem_addr,
   .mem_re, .mem_we, .mem_rdata, .fetch_strobe, .acc_out, .idx_out,
   .ccr_out);
`default_nettype wire

/* File: dv/cad_mem.sv */
// program and data memory model on the far side of the core
// assumes zero wait states: read data valid while the address stands
`timescale 1ns/100ps
`default_nettype none
module cad_mem (
   input  wire logic        ref_clk,
   input  wire logic [15:0] mem_addr,
   input  wire logic        mem_re,
   input  wire logic        mem_we,
   input  wire logic [7:0]  mem_wdata,
   output logic      [7:0]  mem_rdata
);
   // ==========
   // storage, loaded directly by the bench
   logic [7:0] mem [65536];
   logic [7:0] last_rd = 8'h00;
   always @(posedge ref_clk) begin
      if (mem_we)
         mem[mem_addr] <= mem_wdata;
      if (mem_re)
         last_rd <= mem[mem_addr];
   end
   // idle bus shows the inverse of the last read, never a stale copy
   assign mem_rdata = mem_re ? mem[mem_addr] : ~last_rd;
endmodule : cad_mem
`default_nettype wire

/* File: dv/tb_cpu_alu_and_memory_op_decode.sv */
// bench: runs a short program and checks state after each instruction
// assumes cad_core, the memory model and the bound checker
`timescale 1ns/100ps
`default_nettype none
module tb_cpu_alu_and_memory_op_decode;
   // ==========
   // rows: length, bytes, cycles, then acc, idx, ccr afterwards
   typedef struct packed {
      logic [1:0]  len;
      logic [23:0] code;
      logic [3:0]  cyc;
      logic [7:0]  acc;
      logic [7:0]  idx;
      logic [4:0]  ccr;
   } cad_row_t;
   cad_row_t rows [17] = '{
      '{2'h2, 24'ha6c800, 4'h2, 8'hc8, 8'h00, 5'h0c},
      '{2'h2, 24'hae0b00, 4'h2, 8'hc8, 8'h0b, 5'h08},
      '{2'h1, 24'h420000, 4'hb, 8'h98, 8'h08, 5'h08},
      '{2'h1, 24'h990000, 4'h2, 8'h98, 8'h08, 5'h09},
      '{2'h2, 24'ha21000, 4'h2, 8'h87, 8'h08, 5'h0c},
      '{2'h2, 24'ha8ff00, 4'h2, 8'h78, 8'h08, 5'h08},
      '{2'h3, 24'hc61234, 4'h4, 8'h5a, 8'h08, 5'h08},
      '{2'h2, 24'ha15a00, 4'h2, 8'h5a, 8'h08, 5'h0a},
      '{2'h2, 24'ha30800, 4'h2, 8'h5a, 8'h08, 5'h0a},
      '{2'h2, 24'h3c4000, 4'h5, 8'h5a, 8'h08, 5'h0c},
      '{2'h2, 24'h3d4000, 4'h4, 8'h5a, 8'h08, 5'h0c},
      '{2'h1, 24'h490000, 4'h3, 8'hb4, 8'h08, 5'h0c},
      '{2'h1, 24'hf50000, 4'h3, 8'hb4, 8'h08, 5'h0a},
      '{2'h1, 24'h4d0000, 4'h3, 8'hb4, 8'h08, 5'h0c},
      '{2'h1, 24'h9d0000, 4'h2, 8'hb4, 8'h08, 5'h0c},
      '{2'h2, 24'he83800, 4'h4, 8'h34, 8'h08, 5'h08},
      '{2'h3, 24'hd2122c, 4'h5, 8'hda, 8'h08, 5'h0d}};
   logic        ref_clk;
   logic        resetn;
   logic        mem_re, mem_we, fetch_strobe;
   logic [7:0]  mem_wdata, mem_rdata, acc_out, idx_out;
   logic [4:0]  ccr_out;
   logic [15:0] mem_addr, pc_out, p;
   cad_row_t    r;
   int          err_count = 0;
   int          samples_checked = 0;
   int          n;
   cad_core dut (.ref_clk, .resetn, .mem_addr, .mem_re, .mem_we,
      .mem_wdata, .mem_rdata, .fetch_strobe, .acc_out, .idx_out,
      .ccr_out, .pc_out);
   cad_mem mem_i (.ref_clk, .mem_addr, .mem_re, .mem_we, .mem_wdata,
      .mem_rdata);
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic end_of_test();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : end_of_test
   // counts cycles to the next opcode fetch, sampled on the falling edge
   task automatic wait_fetch(output int cyc);
      cyc = 0;
      do begin
         @(negedge ref_clk);
         cyc++;
      end while (fetch_strobe !== 1'b1 && cyc < 40);
      if (fetch_strobe !== 1'b1) begin
         err_count++;
         end_of_test();
      end
   endtask : wait_fetch
   initial begin
      resetn = 1'b0;
      p = 16'h0200;
      for (int a = 0; a < 65536; a++)
         mem_i.mem[a] = 8'h9d;
      mem_i.mem[16'h1ffe] = 8'h02;
      mem_i.mem[16'h1fff] = 8'h00;
      mem_i.mem[16'h1234] = 8'h5a;
      mem_i.mem[16'h0040] = 8'h7f;
      mem_i.mem[16'h0008] = 8'h4b;
      foreach (rows[k])
         for (int i = 0; i < rows[k].len; i++) begin
            mem_i.mem[p] = rows[k].code[23 - 8 * i -: 8];
            p++;
         end
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      wait_fetch(n);
      check("first fetch", mem_addr, 16'h0200);
      foreach (rows[k]) begin
         r = rows[k];
         wait_fetch(n);
         check("cyc", 16'(n), 16'(r.cyc));
         check("acc", 16'(acc_out), 16'(r.acc));
         check("idx", 16'(idx_out), 16'(r.idx));
         check("ccr", 16'(ccr_out), 16'(r.ccr));
      end
      check("mem 0040", 16'(mem_i.mem[16'h0040]), 16'h0080);
      // second reset in mid-run
      @(posedge ref_clk);
      resetn <= 1'b0;
      @(negedge ref_clk);
      check("reset addr", mem_addr, 16'h1ffe);
      check("reset regs", {acc_out, idx_out}, 16'h0000);
      check("reset pc", pc_out, 16'h0000);
      check("reset ccr", 16'(ccr_out), 16'h0008);
      @(posedge ref_clk);
      resetn <= 1'b1;
      wait_fetch(n);
      check("restart", mem_addr, 16'h0200);
      end_of_test();
   end
endmodule : tb_cpu_alu_and_memory_op_decode
`default_nettype wire

/* File: verilog/cad_alu.sv */
// arithmetic and logic unit for register/memory and
// read/modify/write functions; purely combinational
// assumes the sequencer picks operands and applies results
`timescale 1ns/100ps
`default_nettype none
`include "cad_consts.svh"
module cad_alu (
   input  wire logic       rmw,
   input  wire logic [3:0] sel,
   input  wire logic [7:0] a,
   input  wire logic [7:0] m,
   input  wire logic       c_in,
   output logic      [7:0] res,
   output logic            n,
   output logic            z,
   output logic            c,
   output logic            h,
   output logic            upd_nz,
   output logic            upd_c,
   output logic            upd_h,
   output logic            wr
);
   logic [8:0] sum9;
   logic [4:0] lo5;

   always_comb begin
      sum9   = 9'h000;
      lo5    = 5'h00;
      res    = m;
      c      = c_in;
      h      = 1'b0;
      upd_nz = 1'b1;
      upd_c  = 1'b0;
      upd_h  = 1'b0;
      wr     = 1'b1;
      if (!rmw) begin
         case (sel)
            `CAD_RM_SUBTRACT, `CAD_RM_ACC_COMPARE,
            `CAD_RM_INDEX_COMPARE, `CAD_RM_DIFF_WITH_BORROW: begin
               sum9 = {1'b0, a} - {1'b0, m}
                    - {8'h00, c_in & (sel == `CAD_RM_DIFF_WITH_BORROW)};
               res   = sum9[7:0];
               c     = sum9[8];
               upd_c = 1'b1;
               wr    = (sel == `CAD_RM_SUBTRACT) ||
                       (sel == `CAD_RM_DIFF_WITH_BORROW);
            end
            `CAD_RM_AND: res = a & m;
            `CAD_RM_BIT_TEST: begin
               res = a & m;
               wr  = 1'b0;
            end
            `CAD_RM_XOR_WITH_ACC: res = a ^ m;
            `CAD_RM_OR: res = a | m;
            `CAD_RM_ADD, `CAD_RM_ADD_CARRY: begin
               lo5  = {1'b0, a[3:0]} + {1'b0, m[3:0]}
                    + {4'h0, c_in & (sel == `CAD_RM_ADD_CARRY)};
               sum9 = {1'b0, a} + {1'b0, m}
                    + {8'h00, c_in & (sel == `CAD_RM_ADD_CARRY)};
               res   = sum9[7:0];
               c     = sum9[8];
               h     = lo5[4];
               upd_c = 1'b1;
               upd_h = 1'b1;
            end
            `CAD_RM_FETCH_ACC, `CAD_RM_FETCH_INDEX: res = m;
            `CAD_RM_WRITE_ACC, `CAD_RM_WRITE_INDEX: begin
               res = a;
               wr  = 1'b0;
            end
            default: begin
               upd_nz = 1'b0;
               wr     = 1'b0;
            end
         endcase
      end else begin
         upd_c = 1'b1;
         case (sel)
            `CAD_MW_NEGATE: begin
               res = 8'h00 - m;
               c   = (m != 8'h00);
            end
            `CAD_MW_COMPLEMENT: begin
               res = ~m;
               c   = 1'b1;
            end
            `CAD_MW_SHIFT_RIGHT: begin
               res = {1'b0, m[7:1]};
               c   = m[0];
            end
            `CAD_MW_ROTATE_RIGHT: begin
               res = {c_in, m[7:1]};
               c   = m[0];
            end
            `CAD_MW_ARITH_RIGHT: begin
               res = {m[7], m[7:1]};
               c   = m[0];
            end
            `CAD_MW_SHIFT_LEFT: begin
               res = {m[6:0], 1'b0};
               c   = m[7];
            end
            `CAD_MW_CARRY_ROTATE_LEFT: begin
               res = {m[6:0], c_in};
               c   = m[7];
            end
            `CAD_MW_DECREMENT: begin
               res   = m - 8'h01;
               upd_c = 1'b0;
            end
            `CAD_MW_INCREMENT: begin
               res   = m + 8'h01;
               upd_c = 1'b0;
            end
            `CAD_MW_FLAG_PROBE: begin
               upd_c = 1'b0;
               wr    = 1'b0;
            end
            `CAD_MW_CLEAR: begin
               res   = 8'h00;
               upd_c = 1'b0;
            end
            default: begin
               upd_nz = 1'b0;
               upd_c  = 1'b0;
               wr     = 1'b0;
            end
         endcase
      end
      n = res[7];
      z = (res == 8'h00);
   end
endmodule : cad_alu
`default_nettype wire

/* File: verilog/cad_consts.svh */
// opcode fields, cycle counts and fixed addresses of the core
// assumes one byte-wide memory bus and the single processor clock
`ifndef CAD_CONSTS_SVH
`define CAD_CONSTS_SVH

// ==========================================================
// fixed addresses
`define CAD_RST_VEC      16'h1ffe
`define CAD_STACK_PAGE   10'h003
`define CAD_SP_RESET     6'h3f

// ==========================================================
// single opcodes
`define CAD_OP_PRODUCT   8'h42
`define CAD_OP_RETURN    8'h81
`define CAD_OP_TAX       8'h97
`define CAD_OP_CLC       8'h98
`define CAD_OP_SEC       8'h99
`define CAD_OP_CLI       8'h9a
`define CAD_OP_SEI       8'h9b
`define CAD_OP_RSP       8'h9c
`define CAD_OP_TXA       8'h9f

// ==========================================================
// opcode rows (high nibble)
`define CAD_ROW_RMW_DIR  4'h3
`define CAD_ROW_RMW_A    4'h4
`define CAD_ROW_RMW_X    4'h5
`define CAD_ROW_RMW_IX1  4'h6
`define CAD_ROW_RMW_IX   4'h7
`define CAD_ROW_CTL      4'h9
`define CAD_ROW_IMM      4'ha
`define CAD_ROW_DIR      4'hb
`define CAD_ROW_EXT      4'hc
`define CAD_ROW_IX2      4'hd
`define CAD_ROW_IX1      4'he
`define CAD_ROW_IX       4'hf

// ==========================================================
// register/memory functions (low nibble)
`define CAD_RM_SUBTRACT          4'h0
`define CAD_RM_ACC_COMPARE       4'h1
`define CAD_RM_DIFF_WITH_BORROW  4'h2
`define CAD_RM_INDEX_COMPARE     4'h3
`define CAD_RM_AND               4'h4
`define CAD_RM_BIT_TEST          4'h5
`define CAD_RM_FETCH_ACC         4'h6
`define CAD_RM_WRITE_ACC         4'h7
`define CAD_RM_XOR_WITH_ACC      4'h8
`define CAD_RM_ADD_CARRY         4'h9
`define CAD_RM_OR                4'ha
`define CAD_RM_ADD               4'hb
`define CAD_RM_GOTO_TARGET       4'hc
`define CAD_RM_CALL_ROUTINE      4'hd
`define CAD_RM_FETCH_INDEX       4'he
`define CAD_RM_WRITE_INDEX       4'hf

// ==========================================================
// read/modify/write functions (low nibble)
`define CAD_MW_NEGATE            4'h0
`define CAD_MW_COMPLEMENT        4'h3
`define CAD_MW_SHIFT_RIGHT       4'h4
`define CAD_MW_ROTATE_RIGHT      4'h6
`define CAD_MW_ARITH_RIGHT       4'h7
`define CAD_MW_SHIFT_LEFT        4'h8
`define CAD_MW_CARRY_ROTATE_LEFT 4'h9
`define CAD_MW_DECREMENT         4'ha
`define CAD_MW_INCREMENT         4'hc
`define CAD_MW_FLAG_PROBE        4'hd
`define CAD_MW_CLEAR             4'hf

// ==========================================================
// total cycles per instruction
`define CAD_CYC_IMM      4'h2
`define CAD_CYC_DIR      4'h3
`define CAD_CYC_EXT      4'h4
`define CAD_CYC_IX2      4'h5
`define CAD_CYC_IX1      4'h4
`define CAD_CYC_IX       4'h3
`define CAD_CYC_MW_INH   4'h3
`define CAD_CYC_MW_DIR   4'h5
`define CAD_CYC_MW_IX1   4'h6
`define CAD_CYC_MW_IX    4'h5
`define CAD_CYC_PRODUCT  4'hb
`define CAD_CYC_RETURN   4'h6
`define CAD_CYC_CTL      4'h2
`define CAD_CYC_NOP      4'h2

`endif

/* File: verilog/cad_core.sv */
// decode and execute sequencer of the 8-bit core
// assumes asynchronous memory: read data valid in the cycle
// its address stands, write taken at the clock edge with mem_we
`timescale 1ns/100ps
`default_nettype none
`include "cad_consts.svh"
module cad_core
   import cad_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   output logic      [15:0] mem_addr,
   output logic             mem_re,
   output logic             mem_we,
   output logic      [7:0]  mem_wdata,
   input  wire logic [7:0]  mem_rdata,
   output logic             fetch_strobe,
   output logic      [7:0]  acc_out,
   output logic      [7:0]  idx_out,
   output logic      [4:0]  ccr_out,
   output logic      [15:0] pc_out
);
   // ==========================================================
   // decode functions
   function automatic cad_mode_t cad_mode(input logic [7:0] op);
      case (op[7:4])
         `CAD_ROW_RMW_DIR, `CAD_ROW_DIR: cad_mode = M_DIR;
         `CAD_ROW_EXT:                   cad_mode = M_EXT;
         `CAD_ROW_IX2:                   cad_mode = M_IX2;
         `CAD_ROW_RMW_IX1, `CAD_ROW_IX1: cad_mode = M_IX1;
         `CAD_ROW_RMW_IX, `CAD_ROW_IX:   cad_mode = M_IX;
         `CAD_ROW_IMM:                   cad_mode = M_IMM;
         default:                        cad_mode = M_INH;
      endcase
   endfunction : cad_mode

   function automatic cad_kind_t cad_kind(input logic [7:0] op);
      if (op == `CAD_OP_PRODUCT)
         cad_kind = K_PROD;
      else if (op[7:4] >= `CAD_ROW_IMM)
         // immediate stores and jumps do not exist
         cad_kind = (op[7:4] == `CAD_ROW_IMM &&
                     (op[3:0] == `CAD_RM_WRITE_ACC ||
                      op[3:0] >= `CAD_RM_GOTO_TARGET &&
                      op[3:0] != `CAD_RM_FETCH_INDEX)) ? K_NOP : K_RM;
      else if (op[7:4] >= `CAD_ROW_RMW_DIR && op[7:4] <= `CAD_ROW_RMW_IX)
         cad_kind = (op[3:0] inside {4'h1, 4'h2, 4'h5, 4'hb, 4'he})
                    ? K_NOP : K_RMW;
      else if (op[7:4] == `CAD_ROW_CTL || op == `CAD_OP_RETURN)
         cad_kind = K_CTL;
      else
         cad_kind = K_NOP;
   endfunction : cad_kind

   function automatic logic [3:0] cad_cycles(input logic [7:0] op);
      logic [3:0] t;
      t = `CAD_CYC_NOP;
      case (cad_kind(op))
         K_RM: begin
            case (cad_mode(op))
               M_IMM:   t = `CAD_CYC_IMM;
               M_DIR:   t = `CAD_CYC_DIR;
               M_EXT:   t = `CAD_CYC_EXT;
               M_IX2:   t = `CAD_CYC_IX2;
               M_IX1:   t = `CAD_CYC_IX1;
               default: t = `CAD_CYC_IX;
            endcase
            if (op[3:0] == `CAD_RM_WRITE_ACC || op[3:0] == `CAD_RM_WRITE_INDEX)
               t = t + 4'h1;
            else if (op[3:0] == `CAD_RM_GOTO_TARGET)
               t = t - 4'h1;
            else if (op[3:0] == `CAD_RM_CALL_ROUTINE)
               t = t + 4'h2;
         end
         K_RMW: begin
            case (cad_mode(op))
               M_DIR:   t = `CAD_CYC_MW_DIR;
               M_IX1:   t = `CAD_CYC_MW_IX1;
               M_IX:    t = `CAD_CYC_MW_IX;
               default: t = `CAD_CYC_MW_INH;
            endcase
            if (op[3:0] == `CAD_MW_FLAG_PROBE && cad_mode(op) != M_INH)
               t = t - 4'h1;
         end
         K_PROD:  t = `CAD_CYC_PRODUCT;
         K_CTL:   t = (op == `CAD_OP_RETURN) ? `CAD_CYC_RETURN : `CAD_CYC_CTL;
         default: t = `CAD_CYC_NOP;
      endcase
      cad_cycles = t;
   endfunction : cad_cycles

   // ==========================================================
   // state and operand selection
   localparam cad_regs_t RST = '{st: S_VEC1, i: 1'b1, sp: `CAD_SP_RESET,
                                 default: '0};
   cad_regs_t   r_reg;
   cad_regs_t   r_next;
   logic [7:0]  opc;
   cad_kind_t   knd;
   cad_mode_t   mde;
   logic        use_x;
   logic [7:0]  alu_a;
   logic [7:0]  alu_m;
   logic [7:0]  alu_res;
   logic        alu_n;
   logic        alu_z;
   logic        alu_c;
   logic        alu_h;
   logic        alu_unz;
   logic        alu_uc;
   logic        alu_uh;
   logic        alu_wr;
   logic [15:0] product;

   assign opc   = (r_reg.st == S_FETCH) ? mem_rdata : r_reg.op;
   assign knd   = cad_kind(opc);
   assign mde   = cad_mode(opc);
   assign use_x = (knd == K_RM && (opc[3:0] == `CAD_RM_INDEX_COMPARE ||
                   opc[3:0] == `CAD_RM_FETCH_INDEX ||
                   opc[3:0] == `CAD_RM_WRITE_INDEX)) ||
                  (knd == K_RMW && opc[7:4] == `CAD_ROW_RMW_X);
   assign alu_a = use_x ? r_reg.idx : r_reg.acc;
   // inherent read/modify/write works on a register, not on the bus
   assign alu_m = (knd == K_RMW && mde == M_INH) ? alu_a : mem_rdata;
   assign product = {8'h00, r_reg.acc} * {8'h00, r_reg.idx};

   cad_alu u_alu (
      .rmw    (knd == K_RMW),
      .sel    (opc[3:0]),
      .a      (alu_a),
      .m      (alu_m),
      .c_in   (r_reg.c),
      .res    (alu_res),
      .n      (alu_n),
      .z      (alu_z),
      .c      (alu_c),
      .h      (alu_h),
      .upd_nz (alu_unz),
      .upd_c  (alu_uc),
      .upd_h  (alu_uh),
      .wr     (alu_wr)
   );

   // ==========================================================
   // sequencer
   always_comb begin
      logic        done;
      logic        go;
      logic        ex;
      logic        flg;
      logic [15:0] ea_v;
      r_next = r_reg;
      done   = 1'b0;
      go     = 1'b0;
      ex     = 1'b0;
      flg    = 1'b0;
      ea_v   = r_reg.ea;
      r_next.cyc = r_reg.cyc + 4'h1;
      case (r_reg.st)
         S_VEC1: begin
            r_next.pc[15:8] = mem_rdata;
            r_next.st       = S_VEC2;
         end
         S_VEC2: begin
            r_next.pc[7:0] = mem_rdata;
            r_next.st      = S_FETCH;
            r_next.cyc     = 4'h1;
         end
         S_FETCH: begin
            r_next.op = mem_rdata;
            r_next.pc = r_reg.pc + 16'h0001;
            if (knd == K_RM || knd == K_RMW) begin
               if (mde == M_IX) begin
                  ea_v = {8'h00, r_reg.idx};
                  go   = 1'b1;
               end else if (mde == M_INH)
                  ex = 1'b1;
               else
                  r_next.st = S_OPB1;
            end else if (knd == K_PROD) begin
               r_next.idx = product[15:8];
               r_next.acc = product[7:0];
               r_next.h   = 1'b0;
               r_next.c   = 1'b0;
               done       = 1'b1;
            end else if (opc == `CAD_OP_RETURN) begin
               r_next.ph = 1'b0;
               r_next.st = S_STACK;
            end else begin
               done = 1'b1;
               case (opc)
                  `CAD_OP_TAX: r_next.idx = r_reg.acc;
                  `CAD_OP_TXA: r_next.acc = r_reg.idx;
                  `CAD_OP_CLC: r_next.c   = 1'b0;
                  `CAD_OP_SEC: r_next.c   = 1'b1;
                  `CAD_OP_CLI: r_next.i   = 1'b0;
                  `CAD_OP_SEI: r_next.i   = 1'b1;
                  `CAD_OP_RSP: r_next.sp  = `CAD_SP_RESET;
                  default: ;
               endcase
            end
         end
         S_OPB1: begin
            r_next.pc = r_reg.pc + 16'h0001;
            case (mde)
               M_IMM: ex = 1'b1;
               M_DIR: begin
                  ea_v = {8'h00, mem_rdata};
                  go   = 1'b1;
               end
               M_IX1: begin
                  ea_v = {8'h00, mem_rdata} + {8'h00, r_reg.idx};
                  go   = 1'b1;
               end
               default: begin
                  r_next.ea[15:8] = mem_rdata;
                  r_next.st       = S_OPB2;
               end
            endcase
         end
         S_OPB2: begin
            r_next.pc = r_reg.pc + 16'h0001;
            ea_v = {r_reg.ea[15:8], mem_rdata}
                 + ((mde == M_IX2) ? {8'h00, r_reg.idx} : 16'h0000);
            go   = 1'b1;
         end
         S_READ: ex = 1'b1;
         S_WRITE: done = 1'b1;
         S_STACK: begin
            r_next.ph = 1'b1;
            if (opc == `CAD_OP_RETURN) begin
               r_next.sp = r_reg.sp + 6'h01;
               if (!r_reg.ph)
                  r_next.pc[15:8] = mem_rdata;
               else begin
                  r_next.pc[7:0] = mem_rdata;
                  done           = 1'b1;
               end
            end else begin
               // low byte went first, high byte follows
               r_next.sp    = r_reg.sp - 6'h01;
               r_next.wdata = r_reg.pc[15:8];
               if (r_reg.ph) begin
                  r_next.pc = r_reg.ea;
                  done      = 1'b1;
               end
            end
         end
         S_WAIT: done = 1'b1;
         default: r_next.st = S_VEC1;
      endcase

      // effective address known: jump, call, store or read operand
      if (go) begin
         r_next.ea = ea_v;
         if (knd == K_RMW)
            r_next.st = S_READ;
         else if (opc[3:0] == `CAD_RM_GOTO_TARGET) begin
            r_next.pc = ea_v;
            done      = 1'b1;
         end else if (opc[3:0] == `CAD_RM_CALL_ROUTINE) begin
            r_next.wdata = r_next.pc[7:0];
            r_next.ph    = 1'b0;
            r_next.st    = S_STACK;
         end else if (opc[3:0] == `CAD_RM_WRITE_ACC ||
                      opc[3:0] == `CAD_RM_WRITE_INDEX) begin
            r_next.wdata = alu_res;
            flg          = 1'b1;
            r_next.st    = S_WRITE;
         end else
            r_next.st = S_READ;
      end

      // operand in hand: apply the unit's result
      if (ex) begin
         flg = 1'b1;
         if (knd == K_RMW && mde != M_INH) begin
            if (alu_wr) begin
               r_next.wdata = alu_res;
               r_next.st    = S_WRITE;
            end else
               done = 1'b1;
         end else begin
            if (alu_wr && use_x)
               r_next.idx = alu_res;
            else if (alu_wr)
               r_next.acc = alu_res;
            done = 1'b1;
         end
      end
      if (flg) begin
         if (alu_unz) begin
            r_next.n = alu_n;
            r_next.z = alu_z;
         end
         if (alu_uc)
            r_next.c = alu_c;
         if (alu_uh)
            r_next.h = alu_h;
      end

      // pad every instruction to its documented length
      if (done) begin
         if (r_reg.cyc == cad_cycles(opc)) begin
            r_next.st  = S_FETCH;
            r_next.cyc = 4'h1;
         end else
            r_next.st = S_WAIT;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn)
         r_reg <= RST;
      else
         r_reg <= r_next;
   end

   // ==========================================================
   // bus and status outputs
   always_comb begin
      case (r_reg.st)
         S_VEC1:          mem_addr = `CAD_RST_VEC;
         S_VEC2:          mem_addr = `CAD_RST_VEC + 16'h0001;
         S_READ, S_WRITE: mem_addr = r_reg.ea;
         S_STACK:         mem_addr = {`CAD_STACK_PAGE,
                                      (r_reg.op == `CAD_OP_RETURN)
                                      ? r_reg.sp + 6'h01 : r_reg.sp};
         default:         mem_addr = r_reg.pc;
      endcase
   end

   assign mem_we = (r_reg.st == S_WRITE) ||
                   (r_reg.st == S_STACK && r_reg.op != `CAD_OP_RETURN);
   assign mem_re = (r_reg.st inside {S_VEC1, S_VEC2, S_FETCH, S_OPB1,
                    S_OPB2, S_READ}) ||
                   (r_reg.st == S_STACK && r_reg.op == `CAD_OP_RETURN);
   assign mem_wdata    = r_reg.wdata;
   assign fetch_strobe = (r_reg.st == S_FETCH);
   assign acc_out      = r_reg.acc;
   assign idx_out      = r_reg.idx;
   assign ccr_out      = {r_reg.h, r_reg.i, r_reg.n, r_reg.z, r_reg.c};
   assign pc_out       = r_reg.pc;

endmodule : cad_core
`default_nettype wire

/* File: verilog/cad_pkg.sv */
// types shared by the core sequencer
// encodings here are its own; nothing is taken from the constants header
`default_nettype none
package cad_pkg;

   typedef enum logic [8:0] {
      S_VEC1  = 9'h001,
      S_VEC2  = 9'h002,
      S_FETCH = 9'h004,
      S_OPB1  = 9'h008,
      S_OPB2  = 9'h010,
      S_READ  = 9'h020,
      S_WRITE = 9'h040,
      S_STACK = 9'h080,
      S_WAIT  = 9'h100
   } cad_state_t;

   typedef enum logic [2:0] {
      M_INH = 3'h0, M_IMM = 3'h1, M_DIR = 3'h2, M_EXT = 3'h3,
      M_IX2 = 3'h4, M_IX1 = 3'h5, M_IX  = 3'h6
   } cad_mode_t;

   typedef enum logic [2:0] {
      K_NOP = 3'h0, K_RM = 3'h1, K_RMW = 3'h2, K_PROD = 3'h3, K_CTL = 3'h4
   } cad_kind_t;

   typedef struct packed {
      cad_state_t  st;
      logic [15:0] pc;
      logic [15:0] ea;
      logic [7:0]  acc;
      logic [7:0]  idx;
      logic [5:0]  sp;
      logic        h;
      logic        i;
      logic        n;
      logic        z;
      logic        c;
      logic [7:0]  op;
      logic [3:0]  cyc;
      logic        ph;
      logic [7:0]  wdata;
   } cad_regs_t;

endpackage : cad_pkg
`default_nettype wire
